// ==== rtl/swpc_pkg.sv ====
`default_nettype none
package swpc_pkg;
  // Sleep mode selection.
  localparam logic [1:0] SM_NONE = 2'h0;
  localparam logic [1:0] SM_PIN = 2'h1;
  localparam logic [1:0] SM_CYCLIC = 2'h2;
  // Sleep option: associated or deep sleep.
  localparam logic SO_ASSOC = 1'h0;
  localparam logic SO_DEEP = 1'h1;
  // Pin configuration codes.
  localparam logic [2:0] PIN_CFG_PERIPH = 3'h1;
  // Cyclic wake check window, in milliseconds, and its clock count.
  localparam int CLK_HZ = 20000000;
  localparam int WAKE_CHECK_MS = 30;
  localparam int WAKE_CHECK_CYC = (CLK_HZ / 1000) * WAKE_CHECK_MS;
  localparam int PERIOD_W = 32;
  // Reset values.
  localparam logic RST_ASLEEP = 1'h0;
  localparam logic RST_CTS_N = 1'h1;
  localparam logic RST_ATTN = 1'h0;
endpackage
`default_nettype wire

// ==== rtl/swpc_sync_if.sv ====
`default_nettype none
// Synchronised host-side levels passed from the input stage to the controller.
interface swpc_sync_if;
  logic sleep_req;
  logic ssel_n;
  modport src (output sleep_req, output ssel_n);
  modport dst (input sleep_req, input ssel_n);
endinterface
`default_nettype wire

// ==== rtl/swpc_sync.sv ====
`default_nettype none
// ==========================================
// Two-stage synchroniser for the host sleep controls.
module swpc_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sleep_req,
  input wire logic i_ssel_n,
  swpc_sync_if.src o_sync
);
  logic [1:0] meta;
  logic [1:0] stable;
  logic [1:0] next_meta;
  logic [1:0] next_stable;

  // Stage one feeds only stage two, so metastability cannot reach the decision logic.
  always_comb begin
    next_meta = {i_ssel_n, i_sleep_req};
    next_stable = meta;
  end

  // Slave select idles high, so both stages reset to deselected.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta <= 2'h2;
      stable <= 2'h2;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign o_sync.sleep_req = stable[0];
  assign o_sync.ssel_n = stable[1];
endmodule
`default_nettype wire

// ==== rtl/swpc_timer.sv ====
`default_nettype none
// ==========================================
// Down counter: load starts it, done pulses one cycle after the count reaches one.
module swpc_timer #(
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_done,
  output logic o_busy
);
  logic [WIDTH-1:0] count;
  logic busy;
  logic done;
  logic [WIDTH-1:0] next_count;
  logic next_busy;
  logic next_done;

  // A load always restarts the count, even while running.
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (i_load) begin
      next_count = i_count;
      next_busy = 1'b1;
    end else if (busy) begin
      if (count <= 1) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign o_done = done;
  assign o_busy = busy;
endmodule
`default_nettype wire

// ==== rtl/swpc_sleep_ctrl.sv ====
`default_nettype none
module swpc_sleep_ctrl #(
  parameter int PERIOD_W = swpc_pkg::PERIOD_W,
  parameter int WAKE_CHECK_CYC = swpc_pkg::WAKE_CHECK_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_SLEEP_REQUEST_IN,
  input wire logic I_SPI_SSEL_N,
  input wire logic I_IF_IS_SPI,
  input wire logic [1:0] I_SLEEP_MODE_SELECT,
  input wire logic I_SLEEP_OPTION_DEEP,
  input wire logic [2:0] I_FLOW_CTRL_PIN_CFG,
  input wire logic [2:0] I_SLEEP_PIN_CFG,
  input wire logic [2:0] I_STATUS_PIN_CFG,
  input wire logic [2:0] I_SSEL_PIN_CFG,
  input wire logic [PERIOD_W-1:0] I_SLEEP_PERIOD_SETTING,
  input wire logic [PERIOD_W-1:0] I_WAKE_TIME,
  input wire logic I_INIT_DONE,
  input wire logic I_HOST_DATA_PENDING,
  input wire logic I_ACTIVITY,
  input wire logic I_DTIM_BEACON,
  input wire logic I_ASSOCIATED,
  output logic O_ASLEEP,
  output logic O_STATUS_PIN,
  output logic O_CTS_N,
  output logic O_HOST_ATTENTION_OUT,
  output logic O_STATUS_FRAME_REQ,
  output logic O_RX_ENABLE,
  output logic O_DROP_ASSOC,
  output logic O_REASSOC_REQ
);
  typedef enum logic [2:0] {
    ST_AWAKE,
    ST_PIN_SLEEP,
    ST_CYC_SLEEP,
    ST_DTIM_WAIT,
    ST_CHECK,
    ST_STAY
  } swpc_state_type;

  swpc_sync_if sync_bus ();

  swpc_sync u_sync (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_sleep_req(I_SLEEP_REQUEST_IN),
    .i_ssel_n(I_SPI_SSEL_N),
    .o_sync(sync_bus)
  );

  // ==========================================
  // Sleep source selection.
  logic pin_mode;
  logic use_req_pin;
  logic use_ssel;
  logic pin_wants_sleep;

  // On SPI the request pin wins when it is a peripheral; slave select is the fallback.
  always_comb begin
    pin_mode = (I_SLEEP_MODE_SELECT == swpc_pkg::SM_PIN);
    use_req_pin = (I_SLEEP_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH);
    use_ssel = I_IF_IS_SPI && !use_req_pin && (I_SSEL_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH);
    pin_wants_sleep = 1'b0;
    if (use_req_pin) begin
      pin_wants_sleep = sync_bus.sleep_req;
    end else if (use_ssel) begin
      pin_wants_sleep = sync_bus.ssel_n;
    end
  end

  // ==========================================
  // Timers for the sleep period and the wake windows.
  logic period_load;
  logic period_done;
  logic window_load;
  logic window_done;
  logic [PERIOD_W-1:0] window_count;

  swpc_timer #(.WIDTH(PERIOD_W)) u_period (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_load(period_load),
    .i_count(I_SLEEP_PERIOD_SETTING),
    .o_done(period_done),
    .o_busy()
  );

  swpc_timer #(.WIDTH(PERIOD_W)) u_window (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_load(window_load),
    .i_count(window_count),
    .o_done(window_done),
    .o_busy()
  );

  // ==========================================
  // Sleep state machine.
  swpc_state_type state;
  swpc_state_type next_state;
  logic asleep;
  logic next_asleep;
  logic drop;
  logic next_drop;
  logic reassoc;
  logic next_reassoc;

  // A deep sleeper cannot track beacons, so it wakes straight off the period timer.
  always_comb begin
    next_state = state;
    period_load = 1'b0;
    window_load = 1'b0;
    window_count = PERIOD_W'(WAKE_CHECK_CYC);
    next_drop = 1'b0;
    next_reassoc = 1'b0;
    case (state)
      ST_AWAKE: begin
        if (pin_mode && pin_wants_sleep) begin
          next_state = ST_PIN_SLEEP;
          next_drop = I_SLEEP_OPTION_DEEP;
        end else if (I_SLEEP_MODE_SELECT == swpc_pkg::SM_CYCLIC) begin
          next_state = ST_CYC_SLEEP;
          period_load = 1'b1;
          next_drop = I_SLEEP_OPTION_DEEP;
        end
      end
      ST_PIN_SLEEP: begin
        if (!pin_mode || !pin_wants_sleep) begin
          next_state = ST_AWAKE;
          next_reassoc = I_SLEEP_OPTION_DEEP;
        end
      end
      ST_CYC_SLEEP: begin
        if (I_SLEEP_MODE_SELECT != swpc_pkg::SM_CYCLIC) begin
          next_state = ST_AWAKE;
          next_reassoc = I_SLEEP_OPTION_DEEP;
        end else if (period_done) begin
          if (I_SLEEP_OPTION_DEEP) begin
            next_state = ST_CHECK;
            window_load = 1'b1;
            next_reassoc = 1'b1;
          end else begin
            next_state = ST_DTIM_WAIT;
          end
        end
      end
      ST_DTIM_WAIT: begin
        if (I_DTIM_BEACON) begin
          next_state = ST_CHECK;
          window_load = 1'b1;
        end
      end
      ST_CHECK: begin
        if (I_ACTIVITY) begin
          next_state = ST_STAY;
          window_load = 1'b1;
          window_count = I_WAKE_TIME;
        end else if (window_done) begin
          next_state = ST_CYC_SLEEP;
          period_load = 1'b1;
          next_drop = I_SLEEP_OPTION_DEEP;
        end
      end
      ST_STAY: begin
        // Further activity does not restart the wake time.
        if (window_done) begin
          next_state = ST_CYC_SLEEP;
          period_load = 1'b1;
          next_drop = I_SLEEP_OPTION_DEEP;
        end
      end
      default: begin
        next_state = ST_AWAKE;
      end
    endcase
    next_asleep = (next_state == ST_PIN_SLEEP) || (next_state == ST_CYC_SLEEP) ||
      (next_state == ST_DTIM_WAIT);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state <= ST_AWAKE;
      asleep <= swpc_pkg::RST_ASLEEP;
      drop <= 1'b0;
      reassoc <= 1'b0;
    end else begin
      state <= next_state;
      asleep <= next_asleep;
      drop <= next_drop;
      reassoc <= next_reassoc;
    end
  end

  // ==========================================
  // Host-facing outputs.
  logic status_pin;
  logic next_status_pin;
  logic cts_n;
  logic next_cts_n;
  logic attn;
  logic next_attn;
  logic init_seen;
  logic next_init_seen;
  logic status_req;
  logic next_status_req;
  logic rx_en;
  logic next_rx_en;

  // Outputs follow next_asleep so they change in the same cycle as the state.
  always_comb begin
    next_status_pin = (I_STATUS_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH) ? !next_asleep : status_pin;
    next_cts_n = 1'b0;
    if (!I_IF_IS_SPI && I_FLOW_CTRL_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH) begin
      next_cts_n = next_asleep;
    end
    next_rx_en = !next_asleep;
    next_init_seen = init_seen | I_INIT_DONE;
    next_status_req = I_IF_IS_SPI && I_INIT_DONE && !init_seen;
    // Attention is a data flag, not a sleep flag; it rises once at init as well.
    next_attn = I_IF_IS_SPI && (next_status_req || I_HOST_DATA_PENDING);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      status_pin <= 1'b1;
      cts_n <= swpc_pkg::RST_CTS_N;
      attn <= swpc_pkg::RST_ATTN;
      init_seen <= 1'b0;
      status_req <= 1'b0;
      rx_en <= 1'b0;
    end else begin
      status_pin <= next_status_pin;
      cts_n <= next_cts_n;
      attn <= next_attn;
      init_seen <= next_init_seen;
      status_req <= next_status_req;
      rx_en <= next_rx_en;
    end
  end

  assign O_ASLEEP = asleep;
  assign O_STATUS_PIN = status_pin;
  assign O_CTS_N = cts_n;
  assign O_HOST_ATTENTION_OUT = attn;
  assign O_STATUS_FRAME_REQ = status_req;
  assign O_RX_ENABLE = rx_en;
  assign O_DROP_ASSOC = drop;
  assign O_REASSOC_REQ = reassoc;

  // ==========================================
  // Checks.
  chk_status_tracks_sleep: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (I_STATUS_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH) |=> (O_STATUS_PIN == !O_ASLEEP))
    else $error("status pin disagrees with sleep state");
  chk_cts_on_sleep: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (!I_IF_IS_SPI && I_FLOW_CTRL_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH) ##1 $rose(O_ASLEEP) |-> O_CTS_N)
    else $error("cts not high on sleep entry");
  chk_cts_on_wake: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (!I_IF_IS_SPI && I_FLOW_CTRL_PIN_CFG == swpc_pkg::PIN_CFG_PERIPH) ##1 $fell(O_ASLEEP) |-> !O_CTS_N)
    else $error("cts not low on wake");
  chk_rx_blocked: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    O_ASLEEP |-> !O_RX_ENABLE)
    else $error("receive enabled while asleep");
  chk_no_pin_sleep: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_AWAKE && pin_mode && !I_IF_IS_SPI && !use_req_pin) |=> (state != ST_PIN_SLEEP))
    else $error("pin sleep without request pin configured");
  chk_ssel_sleeps: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_AWAKE && pin_mode && use_ssel && sync_bus.ssel_n) |=> O_ASLEEP)
    else $error("slave select negation did not sleep");
  chk_init_attn: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (I_IF_IS_SPI && I_INIT_DONE && !init_seen) |=> (O_HOST_ATTENTION_OUT && O_STATUS_FRAME_REQ))
    else $error("no attention after init");
  chk_deep_reassoc: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_PIN_SLEEP && next_state == ST_AWAKE && I_SLEEP_OPTION_DEEP) |=> O_REASSOC_REQ)
    else $error("deep wake without reassociation");
  chk_dtim_wake: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_DTIM_WAIT && !I_DTIM_BEACON) |=> (state == ST_DTIM_WAIT))
    else $error("associated wake without beacon");
  chk_idle_resleep: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_CHECK && window_done && !I_ACTIVITY) |=> (state == ST_CYC_SLEEP))
    else $error("idle check window did not resume sleep");
  chk_cyclic_enters_sleep: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_AWAKE && I_SLEEP_MODE_SELECT == swpc_pkg::SM_CYCLIC) |=> O_ASLEEP)
    else $error("cyclic mode did not enter sleep");
  chk_req_pin_spi: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
    (state == ST_AWAKE && pin_mode && I_IF_IS_SPI && use_req_pin && sync_bus.sleep_req) |=> O_ASLEEP)
    else $error("request pin did not sleep on spi");
endmodule
`default_nettype wire

// ==== tb/swpc_host_model.sv ====
`default_nettype none
// ==========================================
// Host microcontroller: drives the sleep request and slave select pins.
module swpc_host_model (
  input wire logic i_clk,
  input wire logic i_want_sleep,
  input wire logic i_release_ssel,
  output logic o_sleep_request_in,
  output logic o_spi_ssel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host starts awake with slave select asserted.
  initial begin
    o_sleep_request_in = 1'h0;
    o_spi_ssel_n = 1'h0;
  end
  // Pins move on the falling edge, so the device never samples them mid-change.
  always @(negedge i_clk) begin
    o_sleep_request_in <= i_want_sleep;
    o_spi_ssel_n <= i_release_ssel;
  end
endmodule
`default_nettype wire

// ==== tb/sleep_wake_pin_control_tb_top.sv ====
`default_nettype none
// ==========================================
// Self-checking bench for the sleep and wake controller.
module sleep_wake_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHK = 20;
  // Extended wake time after activity, in clock cycles.
  localparam int WAKE = 8;
  logic clk, rst, want_sleep, rel_ssel, req_pin, ssel_n_pin, if_spi, deep;
  logic init_done, data_pend, activity, dtim;
  logic [1:0] mode;
  logic [2:0] flow_cfg, sleep_cfg, status_cfg, ssel_cfg;
  logic [31:0] period;
  logic asleep, status_pin, cts_n, attn, frame_req, rx_en, drop_assoc, reassoc;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int drops, wakes, awake_after, pulses;
  logic seen_attn;
  // ==========================================
  // Design and host.
  swpc_sleep_ctrl #(.WAKE_CHECK_CYC(CHK)) u_swpc_sleep_ctrl (
    .I_REF_CLK(clk), .I_RESET(rst), .I_SLEEP_REQUEST_IN(req_pin), .I_SPI_SSEL_N(ssel_n_pin),
    .I_IF_IS_SPI(if_spi), .I_SLEEP_MODE_SELECT(mode), .I_SLEEP_OPTION_DEEP(deep),
    .I_FLOW_CTRL_PIN_CFG(flow_cfg), .I_SLEEP_PIN_CFG(sleep_cfg), .I_STATUS_PIN_CFG(status_cfg),
    .I_SSEL_PIN_CFG(ssel_cfg), .I_SLEEP_PERIOD_SETTING(period), .I_WAKE_TIME(32'(WAKE)),
    .I_INIT_DONE(init_done), .I_HOST_DATA_PENDING(data_pend), .I_ACTIVITY(activity),
    .I_DTIM_BEACON(dtim), .I_ASSOCIATED(1'h1), .O_ASLEEP(asleep), .O_STATUS_PIN(status_pin),
    .O_CTS_N(cts_n), .O_HOST_ATTENTION_OUT(attn), .O_STATUS_FRAME_REQ(frame_req),
    .O_RX_ENABLE(rx_en), .O_DROP_ASSOC(drop_assoc), .O_REASSOC_REQ(reassoc));
  swpc_host_model u_swpc_host_model (.i_clk(clk), .i_want_sleep(want_sleep),
    .i_release_ssel(rel_ssel), .o_sleep_request_in(req_pin), .o_spi_ssel_n(ssel_n_pin));
  // ==========================================
  // Clock, and a cycle ceiling well above the roughly eight hundred cycles the tests need.
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Checking and reporting.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reference: whether the pins ask for sleep under the present settings.
  function automatic logic model_sleep(input logic req, input logic ssel_n);
    if (mode != swpc_pkg::SM_PIN) return 1'h0;
    if (!if_spi || sleep_cfg == swpc_pkg::PIN_CFG_PERIPH) return sleep_cfg == swpc_pkg::PIN_CFG_PERIPH && req;
    return ssel_cfg == swpc_pkg::PIN_CFG_PERIPH && ssel_n;
  endfunction
  // Compares the visible sleep state with what the reference expects.
  task automatic check_state(input logic exp);
    check(asleep, exp, "asleep");
    check(status_pin, !exp, "status pin");
    check(cts_n, exp && !if_spi, "cts");
    check(rx_en, !exp, "rx gate");
  endtask
  // Watches a cyclic run; awake stretches between sleeps must last the check window.
  task automatic watch(input int n);
    int run;
    logic slept;
    run = 0;
    slept = 0;
    drops = 0;
    wakes = 0;
    awake_after = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      check(rx_en, !asleep, "rx gate");
      check(status_pin, !asleep, "status pin");
      drops += drop_assoc;
      wakes += reassoc;
      if (asleep) begin
        if (slept && run > 0) check(run >= CHK - 1 && run <= CHK + 2, 1, "check window");
        slept = 1;
        run = 0;
      end else if (slept) begin
        run++;
        awake_after++;
      end
    end
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    logic [2:0] other;
    void'($urandom(29));
    {rst, want_sleep, rel_ssel, if_spi, deep, init_done, data_pend, activity, dtim} = '0;
    rst = 1'h1;
    mode = swpc_pkg::SM_PIN;
    {flow_cfg, status_cfg, ssel_cfg} = {3{swpc_pkg::PIN_CFG_PERIPH}};
    sleep_cfg = swpc_pkg::PIN_CFG_PERIPH;
    period = 32'h10;
    repeat (8) @(negedge clk);
    check(asleep, swpc_pkg::RST_ASLEEP, "reset asleep");
    check(cts_n, swpc_pkg::RST_CTS_N, "reset cts");
    check(attn, swpc_pkg::RST_ATTN, "reset attention");
    rst = 1'h0;
    $display("test reset done");
    // Pin sleep over both interfaces, request pin configured or not, slave select always configured, every pin level.
    for (int i = 0; i < 16; i++) begin
      other = 3'($urandom_range(2, 7));
      if_spi = i[3];
      sleep_cfg = i[2] ? other : swpc_pkg::PIN_CFG_PERIPH;
      want_sleep = i[1];
      rel_ssel = i[0];
      repeat (6) @(negedge clk);
      check_state(model_sleep(want_sleep, rel_ssel));
    end
    $display("test pin sleep done");
    // Attention and the one status indication after initialisation, SPI awake.
    {want_sleep, rel_ssel} = 2'h0;
    repeat (6) @(negedge clk);
    pulses = 0;
    seen_attn = 1'h0;
    for (int k = 0; k < 2; k++) begin
      init_done = 1'h1;
      @(negedge clk);
      init_done = 1'h0;
      // The status pulse stands for one cycle only, so it is sampled right after the init edge.
      pulses += frame_req;
      seen_attn |= attn;
      repeat (8) begin
        @(negedge clk);
        pulses += frame_req;
        seen_attn |= attn;
      end
    end
    check(pulses, 1, "status frame count");
    check(seen_attn, 1, "attention after init");
    data_pend = 1'h1;
    repeat (5) @(negedge clk);
    check(attn, 1, "attention with data");
    check(asleep, 0, "awake with data");
    data_pend = 1'h0;
    repeat (5) @(negedge clk);
    check(attn, 0, "attention cleared");
    $display("test attention done");
    // Cyclic deep sleep on a UART while the host holds the request pin high.
    if_spi = 1'h0;
    want_sleep = 1'h1;
    period = 32'($urandom_range(10, 30));
    deep = swpc_pkg::SO_DEEP;
    mode = swpc_pkg::SM_CYCLIC;
    watch(400);
    check(drops >= 2, 1, "association dropped");
    check(wakes >= 1 && wakes + 1 >= drops && wakes <= drops, 1, "reassociation");
    $display("test cyclic deep done");
    // Associated sleep stays asleep until a beacon with the delivery message arrives.
    @(negedge clk);
    deep = swpc_pkg::SO_ASSOC;
    watch(CHK + 40);
    watch(200);
    check(drops, 0, "association kept");
    check(awake_after, 0, "no wake without beacon");
    // The watch ends just after a rising edge, so the beacon pulse must start on a falling edge.
    @(negedge clk);
    dtim = 1'h1;
    wakes = 0;
    repeat (4) begin
      @(negedge clk);
      dtim = 1'h0;
      wakes += reassoc;
    end
    check(asleep, 0, "wake on beacon");
    check(wakes, 0, "no reassociation");
    // Activity inside the check window keeps the device awake for the wake time, then it sleeps.
    activity = 1'h1;
    @(negedge clk);
    activity = 1'h0;
    repeat (WAKE - 1) @(negedge clk);
    check(asleep, 0, "awake for wake time");
    repeat (3) @(negedge clk);
    check(asleep, 1, "asleep after wake time");
    $display("test cyclic associated done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
